// ==== rtl/serial_register_access_slave_defines.vh ====
`ifndef SERIAL_REGISTER_ACCESS_SLAVE_DEFINES_VH
`define SERIAL_REGISTER_ACCESS_SLAVE_DEFINES_VH

// fixed upper six bits of the seven-bit slave address
`define SRA_ADDR_FIXED 6'h26
// positions inside the slave-address byte
`define SRA_BYTE_RW_BIT 0
`define SRA_BYTE_SEL_BIT 1
// system clock rate in hertz
`define SRA_CLK_HZ 10000000
// clock-low timeout in ms, between the 25 ms floor and 50 ms ceiling
`define SRA_TMO_MS 30
// timeout in system clock cycles
`define SRA_TMO_CYC (`SRA_TMO_MS * (`SRA_CLK_HZ / 1000))
// bit counter values: ninth clock is the acknowledge slot
`define SRA_BIT_ACK 4'h8
`define SRA_BIT_DONE 4'h9
// reset values
`define SRA_RST_BYTE 8'h00
`define SRA_RST_CNT 4'h0

`endif

// ==== rtl/serial_register_access_slave.v ====
`timescale 1ns/1ns
`default_nettype none
`include "serial_register_access_slave_defines.vh"

// write-path buffer; first-word-fall-through, honest full and empty
module sra_write_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_r;
  reg [AW:0] rd_ptr_r;
  wire full;
  wire empty;
  wire push;
  wire pop;

  // extra pointer bit tells full from empty
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) &&
                (wr_ptr_r[AW] != rd_ptr_r[AW]);
  assign o_in_ready = ~full;
  assign o_out_valid = ~empty;
  assign o_out_data = mem[rd_ptr_r[AW-1:0]];
  assign push = i_in_valid & ~full;
  assign pop = i_out_ready & ~empty;

  // storage has no reset; only pointers need a defined value
  always @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= i_in_data;
    end
  end

  // pointer update
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule // sra_write_fifo

module serial_register_access_slave #(
  parameter TIMEOUT_CYC = `SRA_TMO_CYC,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire i_scl,
  input wire i_sda,
  output wire o_sda,
  output wire o_sda_oe,
  input wire i_address_select_pin,
  output wire o_wr_valid,
  input wire i_wr_ready,
  output wire [7:0] o_wr_addr,
  output wire [7:0] o_wr_data,
  output wire [7:0] o_rd_addr,
  input wire [7:0] i_rd_data,
  output wire o_busy,
  output wire o_timeout
);
  localparam [2:0] ST_IDLE = 3'b000;
  localparam [2:0] ST_ADDR = 3'b001;
  localparam [2:0] ST_REG = 3'b010;
  localparam [2:0] ST_WDATA = 3'b011;
  localparam [2:0] ST_RDATA = 3'b100;

  reg scl_s1_r, scl_s2_r, scl_s3_r, scl_f_r, scl_p_r;
  reg sda_s1_r, sda_s2_r, sda_s3_r, sda_f_r, sda_p_r;
  reg sel_s1_r, sel_s2_r;
  reg [2:0] state_r;
  reg [2:0] next_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shreg_r;
  reg [7:0] reg_addr_r;
  reg sda_oe_r;
  reg sda_o_r;
  reg push_r;
  reg [15:0] push_data_r;
  reg busy_r;
  reg timeout_r;
  reg [31:0] low_cnt_r;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire tmo_hit;
  wire fifo_in_ready;
  wire [15:0] fifo_out_data;

  // the select pin is static but still asynchronous, so sync it
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sel_s1_r <= 1'b0;
      sel_s2_r <= 1'b0;
    end else begin
      sel_s1_r <= i_address_select_pin;
      sel_s2_r <= sel_s1_r;
    end
  end

  // two-flop sync, then clock accepted only after two equal samples
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      scl_f_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
      sda_f_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_s1_r <= i_scl;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      if (scl_s2_r == scl_s3_r) begin
        scl_f_r <= scl_s3_r;
      end
      scl_p_r <= scl_f_r;
      // data gets the same delay so start and stop keep their order
      sda_s1_r <= i_sda;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
      sda_f_r <= sda_s3_r;
      sda_p_r <= sda_f_r;
    end
  end

  assign scl_rise = scl_f_r & ~scl_p_r;
  assign scl_fall = ~scl_f_r & scl_p_r;
  // data edge with clock steady high marks start or stop
  assign start_det = scl_f_r & scl_p_r & sda_p_r & ~sda_f_r;
  assign stop_det = scl_f_r & scl_p_r & ~sda_p_r & sda_f_r;
  assign tmo_hit = (low_cnt_r >= TIMEOUT_CYC - 1);

  // clock-low timer; only armed while a transaction is open
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      low_cnt_r <= 32'h0000_0000;
    end else if (scl_f_r || state_r == ST_IDLE) begin
      low_cnt_r <= 32'h0000_0000;
    end else if (!tmo_hit) begin
      low_cnt_r <= low_cnt_r + 32'h0000_0001;
    end
  end

  // byte engine: rising edges sample, falling edges change the line
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= ST_IDLE;
      next_r <= ST_IDLE;
      bit_cnt_r <= `SRA_RST_CNT;
      shreg_r <= `SRA_RST_BYTE;
      reg_addr_r <= `SRA_RST_BYTE;
      sda_oe_r <= 1'b0;
      sda_o_r <= 1'b0;
      push_r <= 1'b0;
      push_data_r <= 16'h0000;
      busy_r <= 1'b0;
      timeout_r <= 1'b0;
    end else begin
      push_r <= 1'b0;
      timeout_r <= 1'b0;
      sda_o_r <= 1'b0;
      busy_r <= (state_r != ST_IDLE);
      if (tmo_hit && state_r != ST_IDLE) begin
        // master may force this by holding the clock low
        state_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
        timeout_r <= 1'b1;
      end else if (start_det) begin
        // repeated start keeps the register address for a read
        state_r <= ST_ADDR;
        bit_cnt_r <= `SRA_RST_CNT;
        sda_oe_r <= 1'b0;
      end else if (stop_det) begin
        state_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else if (state_r != ST_IDLE && scl_rise) begin
        if (bit_cnt_r < `SRA_BIT_ACK) begin
          if (state_r != ST_RDATA) begin
            shreg_r <= {shreg_r[6:0], sda_f_r};
          end
        end else if (state_r == ST_RDATA && sda_f_r) begin
          // master left the byte unacknowledged: wait for stop
          next_r <= ST_IDLE;
        end
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (state_r != ST_IDLE && scl_fall) begin
        if (bit_cnt_r == `SRA_BIT_ACK) begin
          sda_oe_r <= 1'b0;
          case (state_r)
            ST_ADDR: begin
              // only our own address is acknowledged
              if (shreg_r[7:2] == `SRA_ADDR_FIXED &&
                  shreg_r[`SRA_BYTE_SEL_BIT] == sel_s2_r) begin
                sda_oe_r <= 1'b1;
                next_r <= shreg_r[`SRA_BYTE_RW_BIT] ? ST_RDATA : ST_REG;
              end else begin
                next_r <= ST_IDLE;
              end
            end
            ST_REG: begin
              reg_addr_r <= shreg_r;
              sda_oe_r <= 1'b1;
              next_r <= ST_WDATA;
            end
            ST_WDATA: begin
              // a full buffer refuses the byte by leaving it unacked
              if (fifo_in_ready) begin
                push_r <= 1'b1;
                push_data_r <= {reg_addr_r, shreg_r};
                reg_addr_r <= reg_addr_r + 8'h01;
                sda_oe_r <= 1'b1;
              end
              next_r <= ST_WDATA;
            end
            ST_RDATA: begin
              // release for the master's acknowledge, step to next
              reg_addr_r <= reg_addr_r + 8'h01;
              next_r <= ST_RDATA;
            end
            default: begin
              next_r <= ST_IDLE;
            end
          endcase
        end else if (bit_cnt_r == `SRA_BIT_DONE) begin
          state_r <= next_r;
          bit_cnt_r <= `SRA_RST_CNT;
          sda_oe_r <= 1'b0;
          if (next_r == ST_RDATA) begin
            // outside the acknowledge slots, the data line is only driven in read data phases
            shreg_r <= i_rd_data;
            sda_oe_r <= ~i_rd_data[7];
          end
        end else if (state_r == ST_RDATA) begin
          sda_oe_r <= ~shreg_r[3'h7 - bit_cnt_r[2:0]];
        end
      end
    end
  end

  // write path: each accepted data byte becomes one buffered word
  sra_write_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_in_valid(push_r),
    .o_in_ready(fifo_in_ready),
    .i_in_data(push_data_r),
    .o_out_valid(o_wr_valid),
    .i_out_ready(i_wr_ready),
    .o_out_data(fifo_out_data)
  );

  assign o_wr_addr = fifo_out_data[15:8];
  assign o_wr_data = fifo_out_data[7:0];
  assign o_rd_addr = reg_addr_r;
  assign o_sda = sda_o_r;
  assign o_sda_oe = sda_oe_r;
  assign o_busy = busy_r;
  assign o_timeout = timeout_r;
endmodule // serial_register_access_slave

`default_nettype wire

// ==== bench/sra_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
// pin-level checks on the slave's ports
module sra_chk #(
  parameter TIMEOUT_CYC = 200
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_wr_valid,
  input wire logic i_wr_ready,
  input wire logic [7:0] o_wr_addr,
  input wire logic [7:0] o_wr_data,
  input wire logic o_busy,
  input wire logic o_timeout
);
  int lo_r;
  int hi_r;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // run lengths of the raw clock pin, so filter lag never hides a fault
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lo_r <= 0;
      hi_r <= 0;
    end else begin
      lo_r <= i_scl ? 0 : lo_r + 1;
      hi_r <= i_scl ? hi_r + 1 : 0;
    end
  end
  a_sda_low: assert property (!o_sda)
    else $error("data pin driven high");
  a_idle_release: assert property (!o_busy |-> !o_sda_oe)
    else $error("data pulled while idle");
  a_timeout_floor: assert property (o_timeout |-> lo_r > TIMEOUT_CYC / 2)
    else $error("timeout too early");
  a_timeout_release: assert property (lo_r > TIMEOUT_CYC + 20 |->
    !o_sda_oe && !o_busy)
    else $error("timeout did not release");
  a_timeout_pulse: assert property (o_timeout |=> !o_timeout)
    else $error("timeout pulse too long");
  a_wr_hold: assert property (o_wr_valid && !i_wr_ready |=>
    o_wr_valid && $stable({o_wr_addr, o_wr_data}))
    else $error("fifo head moved while stalled");
  a_start_busy: assert property (hi_r > 6 && $fell(i_sda) |-> ##[1:12] o_busy)
    else $error("start not seen");
  a_stop_idle: assert property (hi_r > 6 && $rose(i_sda) |-> ##[1:12] !o_busy)
    else $error("stop not seen");
endmodule // sra_chk
bind serial_register_access_slave sra_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) sra_chk_i (
  .i_ref_clk, .i_resetn, .i_scl, .i_sda, .o_sda, .o_sda_oe, .o_wr_valid,
  .i_wr_ready, .o_wr_addr, .o_wr_data, .o_busy, .o_timeout);
`default_nettype wire

// ==== bench/host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// bus master stand-in; only pulls lines low or lets them float high
module host_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_o
);
  logic glitch = 1'b0;
  // idle: both released; only this side ever moves the clock
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  // wait n edges, then act just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // data moves mid low phase, sampled late in high phase
  // low phase of five cycles covers the slave's synchroniser lag,
  // so its own data changes land before the clock rises again
  task automatic bit_io(input logic b, output logic r);
    tick(3);
    sda_o = b;
    tick(2);
    scl = 1'b1;
    tick(2);
    if (glitch) begin
      scl = 1'b0; // 100 ns dip the filter must hide
      tick(1);
      scl = 1'b1;
      tick(2);
    end
    tick(1);
    r = sda_line;
    scl = 1'b0;
  endtask
  // start or repeated start: data falls, clock high
  task automatic start;
    tick(3);
    sda_o = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(8);
    sda_o = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop;
    tick(3);
    sda_o = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(8);
    sda_o = 1'b1;
    tick(8);
  endtask
  // msb first, then the ninth acknowledge slot
  task automatic xbyte(input logic [7:0] b, input logic a,
                       output logic [7:0] r, output logic ra);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(a, ra);
  endtask
  // clock held low to knock a stuck device back to idle
  task automatic hold_low(input int n);
    tick(n);
    sda_o = 1'b1;
    tick(1);
    scl = 1'b1;
    tick(8);
  endtask
endmodule // host_model
`default_nettype wire

// ==== bench/serial_register_access_slave_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module serial_register_access_slave_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sel = 1'b1;
  logic rdy = 1'b0;
  logic tseen = 1'b0;
  logic scl, msda, a;
  logic [7:0] r;
  wire oe, dsda, vld, busy, tmo;
  wire [7:0] wa, wd, ra;
  int num_errors = 0;
  int n_tests = 0;
  // pin, register, data, expected nack of the address byte
  logic [17:0] rows [3] = '{{1'b1, 8'h00, 8'h5a, 1'b0},
    {1'b1, 8'hff, 8'ha5, 1'b0}, {1'b0, 8'h33, 8'h11, 1'b1}};
  // open-drain data line with pull-up
  wire sda = msda & (oe ? dsda : 1'b1);
  always #50 clk = ~clk;
  always @(posedge clk) if (tmo === 1'b1) tseen <= 1'b1;
  serial_register_access_slave #(.TIMEOUT_CYC(200))
    serial_register_access_slave_i (.i_ref_clk(clk), .i_resetn(rstn),
    .i_scl(scl), .i_sda(sda), .o_sda(dsda), .o_sda_oe(oe),
    .i_address_select_pin(sel), .o_wr_valid(vld), .i_wr_ready(rdy),
    .o_wr_addr(wa), .o_wr_data(wd), .o_rd_addr(ra),
    .i_rd_data(ra ^ 8'h5a), .o_busy(busy), .o_timeout(tmo));
  host_model host_model_i (.clk(clk), .sda_line(sda), .scl(scl),
    .sda_o(msda));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d, comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // take the fifo head; a head that never shows ends the run
  task automatic pop(input logic [7:0] ea, input logic [7:0] ed);
    for (int t = 0; t < 40 && vld !== 1'b1; t++) tick(1);
    if (vld !== 1'b1) begin
      num_errors++;
      report_and_stop;
    end
    chk(wa, ea);
    chk(wd, ed);
    rdy = 1'b1;
    tick(1);
    rdy = 1'b0;
    tick(1);
  endtask
  // start, own address with direction, register byte for a write only
  task automatic open_frame(input logic rw, input logic [7:0] rg);
    host_model_i.start;
    host_model_i.xbyte({6'h26, 1'b1, rw}, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
    if (!rw) host_model_i.xbyte(rg, 1'b1, r, a);
  endtask
  initial begin
    tick(8);
    rstn = 1'b1;
    tick(8);
    chk({4'h0, busy, oe, vld, tmo}, 8'h00);
    chk(ra, 8'h00);
    // single writes; the last row's pin disagrees with the address
    foreach (rows[k]) begin
      sel = rows[k][17];
      tick(4);
      host_model_i.start;
      host_model_i.xbyte({6'h26, 1'b1, 1'b0}, 1'b1, r, a);
      chk({7'h00, a}, {7'h00, rows[k][0]});
      if (!a) begin
        host_model_i.xbyte(rows[k][16:9], 1'b1, r, a);
        host_model_i.xbyte(rows[k][8:1], 1'b1, r, a);
      end
      host_model_i.stop;
      if (!rows[k][0]) pop(rows[k][16:9], rows[k][8:1]);
      chk({7'h00, vld}, 8'h00);
    end
    sel = 1'b1;
    tick(4);
    // burst into a stalled fifo: sixteen fit, the next is refused
    open_frame(1'b0, 8'h10);
    for (int k = 0; k < 17; k++) begin
      host_model_i.glitch = (k == 2);
      host_model_i.xbyte(k[7:0], 1'b1, r, a);
      chk({7'h00, a}, {7'h00, k == 16});
    end
    host_model_i.stop;
    for (int k = 0; k < 16; k++) pop(8'h10 + k[7:0], k[7:0]);
    chk({7'h00, vld}, 8'h00);
    // three reads behind a repeated start, last byte left unacknowledged
    open_frame(1'b0, 8'h20);
    open_frame(1'b1, 8'h00);
    for (int k = 0; k < 3; k++) begin
      host_model_i.xbyte(8'hff, k == 2, r, a);
      chk(r, (8'h20 + k[7:0]) ^ 8'h5a);
    end
    host_model_i.stop;
    chk(ra, 8'h23);
    // clock held low while the device pulls its acknowledge
    host_model_i.start;
    // own write address, msb first
    for (int k = 7; k >= 0; k--)
      host_model_i.bit_io(k == 7 || k == 4 || k == 3 || k == 1, a);
    tick(6);
    chk({7'h00, oe}, 8'h01);
    chk({7'h00, tseen}, 8'h00);
    host_model_i.hold_low(250);
    chk({6'h00, tseen, oe}, 8'h02);
    chk({7'h00, busy}, 8'h00);
    report_and_stop;
  end
endmodule // serial_register_access_slave_test
`default_nettype wire
